// ==== common/emb_map.vh ====
// address map, wait-state defaults and state codes for the external memory interface
`ifndef EMB_MAP_VH
`define EMB_MAP_VH
`define EMB_AW 14
`define EMB_DW 24
`define EMB_PM_WORDS 512
`define EMB_DM_WORDS 256
`define EMB_PM_EXT_BASE0 14'h0800
`define EMB_PM_INT_BASE1 14'h3800
`define EMB_PM_INT_LAST1 14'h39ff
`define EMB_DM_INT_BASE 14'h3800
`define EMB_DM_INT_LAST 14'h38ff
`define EMB_DM_RSV_LAST 14'h3fff
`define EMB_ZONE1_BASE 14'h0800
`define EMB_ZONE2_BASE 14'h1000
`define EMB_ZONE3_BASE 14'h2000
`define EMB_ZONE4_BASE 14'h3000
`define EMB_ZONES 5
`define EMB_WAIT_DM_RST 3'h7
`define EMB_WAIT_PM_RST 3'h7
`define EMB_WAIT_BOOT_RST 3'h3
`define EMB_BOOT_PAGE_RST 3'h0
`define EMB_BOOT_BYTE_W 11
`define EMB_BOOT_LAST_WORD 9'h1ff
`define EMB_ST_IDLE 2'h0
`define EMB_ST_ACC 2'h1
`define EMB_ST_GRANT 2'h2
`define EMB_ST_BOOT 2'h3
`endif

// ==== dv/emb_mem_model.sv ====
// far side memories and boot byte store for the memory interface
`timescale 1ns/10ps
module emb_mem_model
(
  // bus side
  input wire i_ref_clk,
  input wire [13:0] i_addr,
  input wire [1:0] i_page_hi,
  input wire i_pm_n,
  input wire i_dm_n,
  input wire i_bm_n,
  input wire i_rd_n,
  // drive toward the device
  output logic [23:0] o_drive
);
  logic [23:0] last = 24'h0;
  wire on = !i_rd_n && !(i_pm_n && i_dm_n && i_bm_n);
  wire [2:0] pg = {i_page_hi, i_addr[13]};
  always @*
    if (!on)
      o_drive = ~last;
    else if (!i_bm_n)
      o_drive = {8'h00, i_addr[7:0] ^ {pg, i_addr[10:8], 2'h3}, 8'h00};
    else
      o_drive = {i_addr[11:0], ~i_addr[11:0]};
  // idle lines never keep the old value
  always @(posedge i_ref_clk)
    last <= o_drive;
endmodule

// ==== dv/emb_top_chk.sv ====
// port assertions for the memory interface
`timescale 1ns/10ps
module emb_chk
(
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_go_mode,
  input wire i_bus_request_n,
  input wire o_bus_grant_n,
  input wire o_booting,
  input wire o_halted,
  input wire o_req_ready,
  input wire [13:0] o_addr,
  input wire o_addr_oe_n,
  input wire o_data_hi_oe_n,
  input wire o_data_lo_oe_n,
  input wire o_ctl_oe_n,
  input wire o_prog_mem_select_n,
  input wire o_data_memory_select_n,
  input wire o_boot_memory_select_n,
  input wire o_rd_n,
  input wire o_wr_n
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  wire sel = !o_prog_mem_select_n || !o_data_memory_select_n;
  wire strb_off = o_rd_n && o_wr_n;
  sequence s_idle_req;
    !i_bus_request_n && !sel && o_boot_memory_select_n && !o_booting && o_bus_grant_n;
  endsequence
  sequence s_acc2;
    sel ##1 sel;
  endsequence
  AST_GRANT_NEXT: assert property (s_idle_req |=> !o_bus_grant_n)
    else $error("grant late");
  AST_FLOAT: assert property (!o_bus_grant_n |-> o_addr_oe_n && o_data_hi_oe_n && o_data_lo_oe_n && o_ctl_oe_n)
    else $error("bus driven in grant");
  AST_HOLD: assert property (!o_bus_grant_n && !i_bus_request_n |=> !o_bus_grant_n)
    else $error("grant dropped");
  AST_RELEASE: assert property (!o_bus_grant_n && i_bus_request_n |=> o_bus_grant_n && !o_ctl_oe_n && !o_addr_oe_n)
    else $error("grant kept");
  AST_STABLE: assert property (s_acc2 |-> $stable(o_addr) && $stable(o_rd_n) && $stable(o_wr_n))
    else $error("access moved");
  AST_RDWR: assert property (!(!o_rd_n && !o_wr_n))
    else $error("both strobes");
  AST_DM_SEL: assert property (!o_data_memory_select_n |-> o_prog_mem_select_n && o_boot_memory_select_n && (o_rd_n != o_wr_n))
    else $error("bad data cycle");
  AST_BOOT: assert property (!o_boot_memory_select_n |-> !o_rd_n && o_wr_n && !o_data_hi_oe_n && o_data_lo_oe_n)
    else $error("bad boot cycle");
  AST_AFTER_ACC: assert property ($rose(strb_off) && !i_bus_request_n && $past(!i_bus_request_n) |-> ##[0:1] !o_bus_grant_n)
    else $error("no grant after access");
  AST_HALT: assert property (!o_bus_grant_n && !i_go_mode |-> o_halted && !o_req_ready)
    else $error("not halted");
  AST_GO: assert property (!o_bus_grant_n && i_go_mode |-> !o_halted)
    else $error("halted in go mode");
endmodule
bind emb_top emb_chk u_chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_go_mode(i_go_mode),
  .i_bus_request_n(i_bus_request_n), .o_bus_grant_n(o_bus_grant_n), .o_booting(o_booting),
  .o_halted(o_halted), .o_req_ready(o_req_ready), .o_addr(o_addr), .o_addr_oe_n(o_addr_oe_n),
  .o_data_hi_oe_n(o_data_hi_oe_n), .o_data_lo_oe_n(o_data_lo_oe_n), .o_ctl_oe_n(o_ctl_oe_n),
  .o_prog_mem_select_n(o_prog_mem_select_n), .o_data_memory_select_n(o_data_memory_select_n),
  .o_boot_memory_select_n(o_boot_memory_select_n), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n));

// ==== dv/tb.sv ====
// self-checking bench for the memory interface
`timescale 1ns/10ps
module tb;
  typedef struct packed {logic pm; logic wr; logic [13:0] a; logic [23:0] d; logic [3:0] n;} emb_row_t;
  logic i_ref_clk = 1'b0, i_srst, i_memory_map_select, i_cfg_wr, i_force_boot, i_go_mode;
  logic [14:0] i_dm_wait;
  logic [2:0] i_pm_wait, i_boot_wait, i_boot_page;
  logic i_req_valid, i_req_pm, i_req_write, i_bus_request_n;
  logic [13:0] i_req_addr, o_addr;
  logic [23:0] i_req_wdata, o_rdata, o_data, md, wcap, rcap;
  logic o_req_ready, o_rdata_valid, o_booting, o_halted, o_addr_oe_n, o_data_hi_oe_n, o_data_lo_oe_n;
  logic o_prog_mem_select_n, o_data_memory_select_n, o_boot_memory_select_n, o_rd_n, o_wr_n;
  logic o_ctl_oe_n, o_bus_grant_n;
  logic [3:0] sel_cnt = 4'h0;
  logic [3:0] sel_base;
  int bad_count = 0, total_checks = 0;
  wire [23:0] i_data = {o_data_hi_oe_n ? md[23:22] : o_data[23:22], o_data_lo_oe_n ? md[21:0] : o_data[21:0]};
  // zone waits 0,1,2,5,6; program wait 4
  emb_row_t rows [12] = '{
    '{1'b0, 1'b1, 14'h0100, 24'h00a5c3, 4'h1}, '{1'b0, 1'b0, 14'h07ff, 24'h0, 4'h1},
    '{1'b0, 1'b0, 14'h0800, 24'h0, 4'h2}, '{1'b0, 1'b1, 14'h1234, 24'h001e2f, 4'h3},
    '{1'b0, 1'b0, 14'h2345, 24'h0, 4'h6}, '{1'b0, 1'b0, 14'h3000, 24'h0, 4'h7},
    '{1'b0, 1'b1, 14'h37ff, 24'h00c0de, 4'h7}, '{1'b0, 1'b1, 14'h38ff, 24'h00beef, 4'h0},
    '{1'b0, 1'b0, 14'h38ff, 24'h00beef, 4'h0}, '{1'b1, 1'b1, 14'h0005, 24'h5a6b7c, 4'h0},
    '{1'b1, 1'b0, 14'h0005, 24'h5a6b7c, 4'h0}, '{1'b1, 1'b1, 14'h2000, 24'h123456, 4'h5}};
  emb_top uut (.*);
  emb_mem_model u_mem (.i_ref_clk(i_ref_clk), .i_addr(o_addr), .i_page_hi(i_data[23:22]),
    .i_pm_n(o_prog_mem_select_n), .i_dm_n(o_data_memory_select_n), .i_bm_n(o_boot_memory_select_n),
    .i_rd_n(o_rd_n), .o_drive(md));
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    if (!o_prog_mem_select_n || !o_data_memory_select_n)
      sel_cnt <= sel_cnt + 4'h1;
    if (!o_wr_n)
      wcap <= o_data;
    if (o_rdata_valid)
      rcap <= o_rdata;
  end
  function automatic [7:0] bb(input [2:0] p, input [10:0] i);
    bb = i[7:0] ^ {p, i[10:8], 2'h3};
  endfunction
  function automatic [23:0] bw(input [2:0] p, input [10:0] k);
    bw = {bb(p, 3 * k), bb(p, 3 * k + 1), bb(p, 3 * k + 2)};
  endfunction
  task chk(input logic ok, input string m);
    total_checks++;
    if (!ok)
    begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task wrap_up;
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one core access; external write data is seen on the bus, read data at o_rdata
  task acc(input emb_row_t r);
    int k;
    logic [23:0] e;
    @(negedge i_ref_clk) sel_base = sel_cnt;
    @(posedge i_ref_clk);
    i_req_valid <= 1'b1;
    {i_req_pm, i_req_write, i_req_addr, i_req_wdata} <= {r.pm, r.wr, r.a, r.d};
    k = 0;
    do
      @(negedge i_ref_clk);
    while (o_req_ready !== 1'b1 && ++k < 50);
    @(posedge i_ref_clk);
    i_req_valid <= 1'b0;
    repeat (12) @(posedge i_ref_clk);
    e = (r.n == 0) ? r.d : {r.a[11:0], ~r.a[11:0]};
    chk(4'(sel_cnt - sel_base) === r.n, "select length");
    if (r.wr && r.n != 0)
      chk(r.pm ? wcap === r.d : wcap[23:8] === r.d[15:0], "write data");
    else if (!r.wr)
      chk(r.pm ? rcap === e : rcap[15:0] === (r.n == 0 ? e[15:0] : e[23:8]), "read data");
  endtask
  task wait_boot;
    int k;
    k = 0;
    while (o_booting !== 1'b0 && k < 20000)
    begin
      @(negedge i_ref_clk);
      k++;
    end
    chk(k < 20000, "boot hang");
  endtask
  initial
  begin
    {i_req_valid, i_req_pm, i_req_write, i_cfg_wr, i_force_boot, i_go_mode, i_memory_map_select} = 7'h0;
    {i_req_addr, i_req_wdata, i_dm_wait, i_pm_wait, i_boot_wait, i_boot_page} = 0;
    {i_bus_request_n, i_srst} = 2'h3;
    repeat (5) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    repeat (2) @(negedge i_ref_clk);
    chk(o_booting === 1'b1, "no auto boot");
    wait_boot;
    acc('{1'b1, 1'b0, 14'h0000, bw(3'h0, 11'h0), 4'h0});
    acc('{1'b1, 1'b0, 14'h01ff, bw(3'h0, 11'h1ff), 4'h0});
    acc('{1'b1, 1'b0, 14'h0800, 24'h0, 4'h8});
    acc('{1'b0, 1'b0, 14'h0100, 24'h0, 4'h8});
    @(posedge i_ref_clk);
    {i_dm_wait, i_pm_wait, i_boot_wait, i_cfg_wr} <= {15'h6a88, 3'h4, 3'h0, 1'b1};
    @(posedge i_ref_clk);
    i_cfg_wr <= 1'b0;
    for (int i = 0; i < 12; i++)
      acc(rows[i]);
    i_bus_request_n <= 1'b0;
    repeat (3) @(negedge i_ref_clk);
    chk(o_bus_grant_n === 1'b0 && o_halted === 1'b1, "idle grant");
    @(posedge i_ref_clk) i_go_mode <= 1'b1;
    acc(rows[8]);
    @(posedge i_ref_clk) {i_bus_request_n, i_go_mode} <= 2'h2;
    fork
      acc('{1'b0, 1'b0, 14'h3000, 24'h0, 4'h7});
      begin
        repeat (4) @(posedge i_ref_clk);
        i_bus_request_n <= 1'b0;
      end
    join
    chk(o_bus_grant_n === 1'b0, "grant after access");
    @(posedge i_ref_clk) {i_bus_request_n, i_boot_page, i_force_boot} <= {1'b1, 3'h5, 1'b1};
    @(posedge i_ref_clk) i_force_boot <= 1'b0;
    repeat (20) @(posedge i_ref_clk);
    i_bus_request_n <= 1'b0;
    repeat (12) @(negedge i_ref_clk);
    chk(o_bus_grant_n === 1'b0 && o_booting === 1'b1, "boot grant");
    @(posedge i_ref_clk) i_bus_request_n <= 1'b1;
    wait_boot;
    acc('{1'b1, 1'b0, 14'h0000, bw(3'h5, 11'h0), 4'h0});
    acc('{1'b1, 1'b0, 14'h01ff, bw(3'h5, 11'h1ff), 4'h0});
    @(posedge i_ref_clk) {i_bus_request_n, i_srst, i_memory_map_select} <= 3'h3;
    repeat (5) @(negedge i_ref_clk);
    chk(o_bus_grant_n === 1'b0, "grant in reset");
    @(posedge i_ref_clk) {i_bus_request_n, i_srst} <= 2'h2;
    repeat (3) @(negedge i_ref_clk);
    chk(o_booting === 1'b0, "boot with map high");
    acc('{1'b1, 1'b0, 14'h0000, 24'h0, 4'h8});
    acc('{1'b1, 1'b1, 14'h39ff, 24'h778899, 4'h0});
    acc('{1'b1, 1'b0, 14'h39ff, 24'h778899, 4'h0});
    acc('{1'b0, 1'b0, 14'h3900, 24'h0, 4'h0});
    wrap_up;
  end
  // two boots dominate the run
  initial
  begin
    repeat (80000) @(posedge i_ref_clk);
    bad_count++;
    wrap_up;
  end
endmodule

// ==== src/emb_boot_pack.v ====
// packs boot bytes, first byte highest, into 24-bit words
`timescale 1ns/10ps
module emb_boot_pack
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // byte side
  input wire i_clear,
  input wire i_byte_valid,
  input wire [7:0] i_byte,
  // word side
  output reg [23:0] o_word,
  output reg o_word_valid
);
  reg [1:0] idx;
  reg [15:0] part;

  always @(posedge i_ref_clk)
  begin
    if (i_srst || i_clear)
    begin
      idx <= 2'h0;
      part <= 16'h0000;
      o_word <= 24'h000000;
      o_word_valid <= 1'b0;
    end
    else
    begin
      o_word_valid <= 1'b0;
      if (i_byte_valid)
      begin
        if (idx == 2'h2)
        begin
          o_word <= {part, i_byte};
          o_word_valid <= 1'b1;
          idx <= 2'h0;
        end
        else
        begin
          part <= {part[7:0], i_byte};
          idx <= idx + 2'h1;
        end
      end
    end
  end
endmodule

// ==== src/emb_top.v ====
// external memory, boot loader and bus handover interface
//
// Functional notes
// - map select low: program RAM 512 words at 0x0000, external from 0x0800.
// - map select low: boot page 0 loads automatically when reset is released.
// - map select high: external program from 0x0000, RAM at 0x3800-0x39FF.
// - map select high: no boot after reset; program RAM still readable and writable.
// - 14-bit data addresses; data memory data on upper 16 data lines.
// - data select for data accesses, write strobe for writes, read strobe for reads.
// - mapped peripherals use the same bus cycles as data memory.
// - data RAM 256 words at 0x3800; up to 0x3FFF reserved; rest external.
// - external data memory split into five zones with own wait counts.
// - every data zone has seven wait states after reset.
// - 16K boot bytes in eight 2K pages; bytes packed into 24-bit words.
// - boot page from three-bit field; force-boot bit starts a boot.
// - boot reads use zero to seven wait states, three after reset.
// - boot uses boot select and read strobe; byte taken from D8-D15.
// - boot page driven on D23, D22 and A13 during boot reads.
// - bus request during boot: finish current byte, then grant.
// - request with no access: next cycle float bus, grant, halt.
// - keep-running mode: grant but run until an external access is needed.
// - request during an access: grant the cycle after it completes.
// - bus may be granted between accesses of one instruction.
// - request withdrawn: release grant, drive bus again, resume where stopped.
// - bus requests honoured always, also during boot and reset.
// - external program accesses use zero to seven waits, seven after reset.
// - program select asserted for external program accesses.
`timescale 1ns/10ps
`include "emb_map.vh"
module emb_top
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // configuration
  input wire i_memory_map_select,
  input wire i_cfg_wr,
  input wire [14:0] i_dm_wait,
  input wire [2:0] i_pm_wait,
  input wire [2:0] i_boot_wait,
  input wire [2:0] i_boot_page,
  input wire i_force_boot,
  input wire i_go_mode,
  // core request port
  input wire i_req_valid,
  input wire i_req_pm,
  input wire i_req_write,
  input wire [13:0] i_req_addr,
  input wire [23:0] i_req_wdata,
  output wire o_req_ready,
  output reg [23:0] o_rdata,
  output reg o_rdata_valid,
  // status
  output wire o_booting,
  output wire o_halted,
  // external address and data bus
  output reg [13:0] o_addr,
  output wire o_addr_oe_n,
  input wire [23:0] i_data,
  output reg [23:0] o_data,
  output wire o_data_hi_oe_n,
  output wire o_data_lo_oe_n,
  // selects and strobes
  output wire o_prog_mem_select_n,
  output wire o_data_memory_select_n,
  output wire o_boot_memory_select_n,
  output wire o_rd_n,
  output wire o_wr_n,
  output wire o_ctl_oe_n,
  // bus handover
  input wire i_bus_request_n,
  output wire o_bus_grant_n
);
  reg [1:0] state;
  reg [1:0] next_state;
  reg acc_pm;
  reg acc_wr;
  reg [2:0] wait_dm [0:`EMB_ZONES-1];
  reg [2:0] wait_pm;
  reg [2:0] wait_boot;
  reg [2:0] page;
  reg boot_pend;
  reg [10:0] boot_byte;
  reg [8:0] boot_word;
  reg [23:0] pm_ram [0:`EMB_PM_WORDS-1];
  reg [15:0] dm_ram [0:`EMB_DM_WORDS-1];
  reg [2:0] load_count;
  reg rst_q;
  wire acc_done;
  wire [23:0] pk_word;
  wire pk_valid;
  wire br;
  wire req_ext;
  wire req_int;
  wire take_ext;
  wire take_int;
  wire boot_byte_done;
  wire start_boot;
  genvar z;

  assign br = ~i_bus_request_n;

  // program space decode, depends on map select
  function pm_is_ext;
    input [13:0] a;
    input mm;
    begin
      if (!mm)
        pm_is_ext = (a >= `EMB_PM_EXT_BASE0);
      else
        pm_is_ext = (a < `EMB_PM_INT_BASE1) || (a > `EMB_PM_INT_LAST1);
    end
  endfunction

  // data zone index for external data addresses
  function [2:0] dm_zone;
    input [13:0] a;
    begin
      if (a < `EMB_ZONE1_BASE)
        dm_zone = 3'h0;
      else if (a < `EMB_ZONE2_BASE)
        dm_zone = 3'h1;
      else if (a < `EMB_ZONE3_BASE)
        dm_zone = 3'h2;
      else if (a < `EMB_ZONE4_BASE)
        dm_zone = 3'h3;
      else
        dm_zone = 3'h4;
    end
  endfunction

  // peripherals above 0x3FFF do not exist, everything below RAM is external
  assign req_ext = i_req_pm ? pm_is_ext(i_req_addr, i_memory_map_select)
                            : (i_req_addr < `EMB_DM_INT_BASE);
  assign req_int = ~req_ext;

  // an external request yields to a pending bus request, so grant wins ties
  assign take_ext = i_req_valid && req_ext && (state == `EMB_ST_IDLE) && !br && !boot_pend;
  // internal work continues under grant only in keep-running mode
  assign take_int = i_req_valid && req_int && !boot_pend &&
                    ((state == `EMB_ST_IDLE && !br) || (state == `EMB_ST_GRANT && i_go_mode));
  assign o_req_ready = req_ext ? take_ext : take_int;

  assign boot_byte_done = (state == `EMB_ST_BOOT) && acc_done;
  assign start_boot = boot_pend && (state == `EMB_ST_IDLE) && !br;

  // per-zone wait states, seven after reset
  generate
    for (z = 0; z < `EMB_ZONES; z = z + 1)
    begin : g_zone
      always @(posedge i_ref_clk)
      begin
        if (i_srst)
          wait_dm[z] <= `EMB_WAIT_DM_RST;
        else if (i_cfg_wr)
          wait_dm[z] <= i_dm_wait[z*3 +: 3];
      end
    end
  endgenerate

  always @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      wait_pm <= `EMB_WAIT_PM_RST;
      wait_boot <= `EMB_WAIT_BOOT_RST;
    end
    else if (i_cfg_wr)
    begin
      wait_pm <= i_pm_wait;
      wait_boot <= i_boot_wait;
    end
  end

  // wait count chosen for the access about to start
  always @*
  begin
    load_count = 3'h0;
    if (start_boot || (state == `EMB_ST_BOOT))
      load_count = wait_boot;
    else if (i_req_pm)
      load_count = wait_pm;
    else
      load_count = wait_dm[dm_zone(i_req_addr)];
  end

  emb_wait_ctr u_wait
  (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_load(take_ext || start_boot || (boot_byte_done && !pk_last_byte(1'b0) && !br)),
    .i_count(load_count),
    .o_done(acc_done)
  );

  emb_boot_pack u_pack
  (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_clear(start_boot && boot_byte == 11'h000),
    .i_byte_valid(boot_byte_done),
    .i_byte(i_data[15:8]),
    .o_word(pk_word),
    .o_word_valid(pk_valid)
  );

  // next state
  always @*
  begin
    next_state = state;
    case (state)
      `EMB_ST_IDLE:
      begin
        if (br)
          next_state = `EMB_ST_GRANT;
        else if (start_boot)
          next_state = `EMB_ST_BOOT;
        else if (take_ext)
          next_state = `EMB_ST_ACC;
      end
      `EMB_ST_ACC:
      begin
        if (acc_done)
          next_state = `EMB_ST_IDLE;
      end
      `EMB_ST_BOOT:
      begin
        if (acc_done && (br || boot_byte_done && pk_last_byte(1'b0)))
          next_state = `EMB_ST_IDLE;
      end
      `EMB_ST_GRANT:
      begin
        if (!br)
          next_state = `EMB_ST_IDLE;
      end
      default:
        next_state = `EMB_ST_IDLE;
    endcase
  end

  // last byte of the 512th word ends the boot
  function pk_last_byte;
    input dummy;
    begin
      pk_last_byte = (boot_word == `EMB_BOOT_LAST_WORD) && (boot_byte % 3 == 2);
    end
  endfunction

  // state register and bus hold through reset
  always @(posedge i_ref_clk)
  begin
    if (i_srst)
      state <= br ? `EMB_ST_GRANT : `EMB_ST_IDLE;
    else
      state <= next_state;
  end

  // boot control
  always @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      boot_pend <= 1'b0;
      page <= `EMB_BOOT_PAGE_RST;
      boot_byte <= 11'h000;
      boot_word <= 9'h000;
    end
    else
    begin
      if (rst_q && !i_memory_map_select)
      begin
        boot_pend <= 1'b1;
        page <= `EMB_BOOT_PAGE_RST;
      end
      else if (i_force_boot && !boot_pend)
      begin
        boot_pend <= 1'b1;
        page <= i_boot_page;
        boot_byte <= 11'h000;
        boot_word <= 9'h000;
      end
      if (boot_byte_done)
      begin
        boot_byte <= boot_byte + 11'h001;
        if (pk_last_byte(1'b0))
          boot_pend <= 1'b0;
      end
      if (pk_valid)
        boot_word <= boot_word + 9'h001;
    end
  end

  // one cycle after reset release, picks up the map strap
  always @(posedge i_ref_clk)
  begin
    rst_q <= i_srst;
  end

  // pins: address, data and which access runs
  always @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_addr <= 14'h0000;
      o_data <= 24'h000000;
      acc_pm <= 1'b0;
      acc_wr <= 1'b0;
    end
    else if (take_ext)
    begin
      o_addr <= i_req_addr;
      acc_pm <= i_req_pm;
      acc_wr <= i_req_write;
      o_data <= i_req_pm ? i_req_wdata : {i_req_wdata[15:0], 8'h00};
    end
    else if (start_boot || (boot_byte_done && !br))
    begin
      o_addr <= {page[0], 2'h0, boot_byte + {10'h000, boot_byte_done}};
      o_data <= {page[2:1], 22'h000000};
      acc_pm <= 1'b0;
      acc_wr <= 1'b0;
    end
  end

  // selects and strobes are active only while an access runs
  assign o_prog_mem_select_n = !(state == `EMB_ST_ACC && acc_pm);
  assign o_data_memory_select_n = !(state == `EMB_ST_ACC && !acc_pm);
  assign o_boot_memory_select_n = !(state == `EMB_ST_BOOT);
  assign o_rd_n = !((state == `EMB_ST_ACC && !acc_wr) || state == `EMB_ST_BOOT);
  assign o_wr_n = !(state == `EMB_ST_ACC && acc_wr);

  // address and control drivers float only while granted; data lines are driven only for writes and boot reads
  assign o_bus_grant_n = !(state == `EMB_ST_GRANT);
  assign o_addr_oe_n = (state == `EMB_ST_GRANT);
  assign o_ctl_oe_n = (state == `EMB_ST_GRANT);
  assign o_data_hi_oe_n = !((state == `EMB_ST_ACC && acc_wr) || state == `EMB_ST_BOOT);
  assign o_data_lo_oe_n = !(state == `EMB_ST_ACC && acc_wr);

  assign o_booting = boot_pend;
  assign o_halted = (state == `EMB_ST_GRANT) && !i_go_mode;

  // on-chip memories
  always @(posedge i_ref_clk)
  begin
    if (pk_valid)
      pm_ram[boot_word] <= pk_word;
    else if (take_int && i_req_pm && i_req_write)
      pm_ram[i_req_addr[8:0]] <= i_req_wdata;
    if (take_int && !i_req_pm && i_req_write && i_req_addr <= `EMB_DM_INT_LAST)
      dm_ram[i_req_addr[7:0]] <= i_req_wdata[15:0];
  end

  // read answers: internal next cycle, external at the end of the access
  always @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_rdata <= 24'h000000;
      o_rdata_valid <= 1'b0;
    end
    else
    begin
      o_rdata_valid <= 1'b0;
      if (take_int)
      begin
        o_rdata_valid <= 1'b1;
        if (i_req_pm)
          o_rdata <= pm_ram[i_req_addr[8:0]];
        else if (i_req_addr <= `EMB_DM_INT_LAST)
          o_rdata <= {8'h00, dm_ram[i_req_addr[7:0]]};
        else
          o_rdata <= 24'h000000;
      end
      else if (state == `EMB_ST_ACC && acc_done)
      begin
        o_rdata_valid <= 1'b1;
        o_rdata <= acc_pm ? i_data : {8'h00, i_data[23:8]};
      end
    end
  end
endmodule

// ==== src/emb_wait_ctr.v ====
// wait-state down counter for one external access
`timescale 1ns/10ps
module emb_wait_ctr
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // load and status
  input wire i_load,
  input wire [2:0] i_count,
  output wire o_done
);
  reg [2:0] cnt;

  always @(posedge i_ref_clk)
  begin
    if (i_srst)
      cnt <= 3'h0;
    else if (i_load)
      cnt <= i_count;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end

  assign o_done = (cnt == 3'h0);
endmodule
